// file: hdl/amg_pkg.sv
// Summary of operation
// - Protected: RAM allowed except OS stack, work
// - Protected: shared coprocessor RAM needs explicit enable
// - Protected: everything outside RAM denied, bar exceptions
// - Protected: application and both relief areas allowed
// - Protected: registers allowed except system control register
// - Unprotected: every access allowed
// - Decision uses only status and target area
// - Rule changes take effect only when unprotected
// - Only unprotected software turns protection on
// - Protected call into call relief or return into return relief clears protection
// - Taken interrupt clears protection
// - Attributes reset to permissive values
// - Unprotected software may load new attributes
// - Current role always tracked and visible
// - Denied access raises chip reset request
package amg_pkg;

	// ==========================================
	// Address map
	localparam int          AW            = 24;
	localparam int          NUM_AREAS     = 6;
	localparam int          A_OS_STACK    = 0;
	localparam int          A_OS_WORK     = 1;
	localparam int          A_CPRAM       = 2;
	localparam int          A_APP         = 3;
	localparam int          A_CALL_RELIEF = 4;
	localparam int          A_RET_RELIEF  = 5;
	localparam logic [23:0] RAM_LO        = 24'h000000;
	localparam logic [23:0] RAM_HI        = 24'h00ffff;
	localparam logic [23:0] GPR_LO        = 24'h010000;
	localparam logic [23:0] GPR_HI        = 24'h0100ff;
	localparam logic [23:0] SYSCTL_ADDR   = 24'h010000;
	// Empty window: base above limit, so nothing matches
	localparam logic [23:0] AREA_BASE_RST = 24'hffffff;
	localparam logic [23:0] AREA_LIM_RST  = 24'h000000;

	// ==========================================
	// Register map
	localparam logic [11:0] OFF_CTRL      = 12'h000;
	localparam logic [11:0] OFF_STATE     = 12'h004;
	localparam logic [11:0] OFF_IRQ_STAT  = 12'h008;
	localparam logic [11:0] OFF_IRQ_MASK  = 12'h00c;
	localparam logic [11:0] OFF_AREA0     = 12'h010;
	localparam logic [11:0] OFF_AREA_END  = 12'h03c;
	localparam int          CTRL_ON_BIT   = 0;
	localparam int          CTRL_CPEN_BIT = 1;
	localparam int          ST_PROT_BIT   = 0;
	localparam int          ST_ROLE_BIT   = 1;
	localparam int          ST_RST_BIT    = 2;
	localparam int          NUM_EV        = 4;
	localparam int          EV_DENY       = 0;
	localparam int          EV_CALL_OFF   = 1;
	localparam int          EV_RET_OFF    = 2;
	localparam int          EV_IRQ_OFF    = 3;

	// ==========================================
	// Types
	typedef struct packed {
		logic          valid;
		logic          write;
		logic [AW-1:0] addr;
	} amg_cpu_req_t;

	typedef struct packed {
		logic          call;
		logic          ret;
		logic          irq_take;
		logic [AW-1:0] target;
	} amg_flow_t;

	typedef struct packed {
		logic [AW-1:0] base;
		logic [AW-1:0] limit;
	} amg_area_t;

	typedef struct packed {
		logic                         prot;
		logic                         cpram_en;
		amg_area_t [NUM_AREAS-1:0]    areas;
		amg_cpu_req_t                 mem_req;
		logic                         denied;
		logic                         rst_req;
		logic                         pready;
		logic                         pslverr;
		logic [31:0]                  prdata;
	} amg_guard_st_t;

	typedef struct packed {
		logic [NUM_EV-1:0] stat;
		logic [NUM_EV-1:0] mask;
		logic              irq;
	} amg_irq_st_t;

	function automatic logic in_range(input logic [AW-1:0] a, input logic [AW-1:0] lo,
		input logic [AW-1:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

endpackage

// file: hdl/amg_area_dec.sv
module amg_area_dec
	import amg_pkg::*;
(
	input  wire logic [amg_pkg::AW-1:0]                 addr,
	input  wire amg_pkg::amg_area_t [amg_pkg::NUM_AREAS-1:0] areas,
	output logic [amg_pkg::NUM_AREAS-1:0]               hit
);
	// ==========================================
	// One comparator pair per window
	genvar i;
	generate
		for (i = 0; i < NUM_AREAS; i++) begin : g_win
			assign hit[i] = in_range(addr, areas[i].base, areas[i].limit);
		end
	endgenerate
endmodule // amg_area_dec

// file: hdl/amg_irq.sv
module amg_irq
	import amg_pkg::*;
(
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic [amg_pkg::NUM_EV-1:0] ev_set,
	input  wire logic                      stat_wr,
	input  wire logic                      mask_wr,
	input  wire logic [amg_pkg::NUM_EV-1:0] wdata,
	output logic [amg_pkg::NUM_EV-1:0]      stat,
	output logic [amg_pkg::NUM_EV-1:0]      mask,
	output logic                           irq
);
	amg_irq_st_t st_ff;
	amg_irq_st_t nxt_st;

	// ==========================================
	// Sticky status, write one to clear
	always_comb begin
		nxt_st = st_ff;
		// Set beats clear so no event is lost
		nxt_st.stat = (st_ff.stat & ~(stat_wr ? wdata : '0)) | ev_set;
		if (mask_wr) begin
			nxt_st.mask = wdata;
		end
		nxt_st.irq = |(nxt_st.stat & nxt_st.mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign stat = st_ff.stat;
	assign mask = st_ff.mask;
	assign irq  = st_ff.irq;
endmodule // amg_irq

// file: hdl/amg_guard.sv
// Our own choices: the placing of the registers and register access over APB.
module amg_guard
	import amg_pkg::*;
(
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	// CPU side
	input  wire amg_pkg::amg_cpu_req_t  cpu_req,
	input  wire amg_pkg::amg_flow_t     cpu_flow,
	// Memory side
	output amg_pkg::amg_cpu_req_t       mem_req,
	output logic                        access_denied,
	output logic                        chip_rst_req,
	output logic                        prot_status,
	output logic                        irq
);
	// ==========================================
	// State
	amg_guard_st_t           st_ff;
	amg_guard_st_t           nxt_st;
	logic [NUM_AREAS-1:0]    req_hit;
	logic [NUM_AREAS-1:0]    tgt_hit;
	logic [NUM_EV-1:0]       ev_set;
	logic [NUM_EV-1:0]       irq_stat;
	logic [NUM_EV-1:0]       irq_mask;
	logic                    irq_q;
	logic                    allowed;
	logic                    apb_setup;
	logic                    apb_wr;
	logic                    stat_wr;
	logic                    mask_wr;
	logic                    call_off;
	logic                    ret_off;
	logic                    leave_prot;

	// ==========================================
	// APB decode helpers
	function automatic logic is_area_off(input logic [11:0] a);
		is_area_off = (a >= OFF_AREA0) && (a <= OFF_AREA_END) && (a[1:0] == 2'b00);
	endfunction

	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a == OFF_CTRL) || (a == OFF_STATE) || (a == OFF_IRQ_STAT)
			|| (a == OFF_IRQ_MASK) || is_area_off(a);
	endfunction

	// Window index and base/limit select from the offset
	function automatic int area_idx(input logic [11:0] a);
		logic [11:0] rel;
		rel = a - OFF_AREA0;
		area_idx = int'(rel[11:3]);
	endfunction

	// ==========================================
	// Area classification
	amg_area_dec u_req_dec (
		.addr  (cpu_req.addr),
		.areas (st_ff.areas),
		.hit   (req_hit)
	);

	// Relief check uses the branch target, not the data address
	amg_area_dec u_tgt_dec (
		.addr  (cpu_flow.target),
		.areas (st_ff.areas),
		.hit   (tgt_hit)
	);

	// ==========================================
	// Access decision
	logic in_ram;
	logic in_gpr;
	logic ram_ok;
	logic gpr_ok;
	logic cpram_ok;
	logic exc_ok;

	always_comb begin
		in_ram   = in_range(cpu_req.addr, RAM_LO, RAM_HI);
		in_gpr   = in_range(cpu_req.addr, GPR_LO, GPR_HI);
		// OS windows and a closed shared window carve holes in RAM
		ram_ok   = in_ram && !req_hit[A_OS_STACK] && !req_hit[A_OS_WORK]
			&& !(req_hit[A_CPRAM] && !st_ff.cpram_en);
		cpram_ok = req_hit[A_CPRAM] && st_ff.cpram_en;
		exc_ok   = req_hit[A_APP] || req_hit[A_CALL_RELIEF] || req_hit[A_RET_RELIEF];
		gpr_ok   = in_gpr && (cpu_req.addr != SYSCTL_ADDR);
		// Status and target area only; no history or data enter here
		allowed  = !st_ff.prot || ram_ok || cpram_ok || exc_ok || gpr_ok;
	end

	// ==========================================
	// Protect status transitions
	always_comb begin
		call_off   = st_ff.prot && cpu_flow.call && tgt_hit[A_CALL_RELIEF];
		ret_off    = st_ff.prot && cpu_flow.ret && tgt_hit[A_RET_RELIEF];
		leave_prot = call_off || ret_off || (st_ff.prot && cpu_flow.irq_take);
	end

	// ==========================================
	// APB strobes
	always_comb begin
		apb_setup = psel && !penable;
		apb_wr    = psel && penable && st_ff.pready && pwrite && is_mapped(paddr);
		stat_wr   = apb_wr && (paddr == OFF_IRQ_STAT);
		mask_wr   = apb_wr && (paddr == OFF_IRQ_MASK);
	end

	// ==========================================
	// Events
	always_comb begin
		ev_set              = '0;
		ev_set[EV_DENY]     = cpu_req.valid && !allowed;
		ev_set[EV_CALL_OFF] = call_off;
		ev_set[EV_RET_OFF]  = ret_off;
		ev_set[EV_IRQ_OFF]  = st_ff.prot && cpu_flow.irq_take;
	end

	amg_irq u_irq (
		.pclk    (pclk),
		.presetn (presetn),
		.ev_set  (ev_set),
		.stat_wr (stat_wr),
		.mask_wr (mask_wr),
		.wdata   (pwdata[NUM_EV-1:0]),
		.stat    (irq_stat),
		.mask    (irq_mask),
		.irq     (irq_q)
	);

	// ==========================================
	// Read mux
	function automatic logic [31:0] read_word(input logic [11:0] a);
		logic [31:0] w;
		int          k;
		w = '0;
		k = area_idx(a);
		if (a == OFF_CTRL) begin
			w[CTRL_ON_BIT]   = st_ff.prot;
			w[CTRL_CPEN_BIT] = st_ff.cpram_en;
		end else if (a == OFF_STATE) begin
			w[ST_PROT_BIT] = st_ff.prot;
			w[ST_ROLE_BIT] = !st_ff.prot;
			w[ST_RST_BIT]  = st_ff.rst_req;
		end else if (a == OFF_IRQ_STAT) begin
			w[NUM_EV-1:0] = irq_stat;
		end else if (a == OFF_IRQ_MASK) begin
			w[NUM_EV-1:0] = irq_mask;
		end else if (is_area_off(a) && (k < NUM_AREAS)) begin
			w[AW-1:0] = a[2] ? st_ff.areas[k].limit : st_ff.areas[k].base;
		end
		read_word = w;
	endfunction

	// ==========================================
	// Next state
	always_comb begin
		int k;
		k      = area_idx(paddr);
		nxt_st = st_ff;

		// Single wait-free access phase
		nxt_st.pready = apb_setup;
		if (apb_setup) begin
			nxt_st.prdata  = pwrite ? '0 : read_word(paddr);
			// Locked writes are flagged so software sees the refusal
			nxt_st.pslverr = !is_mapped(paddr)
				|| (pwrite && st_ff.prot && ((paddr == OFF_CTRL) || is_area_off(paddr)));
		end else if (!psel) begin
			nxt_st.pslverr = 1'b0;
		end

		// Configuration only moves while unprotected
		if (apb_wr && !st_ff.prot) begin
			if (paddr == OFF_CTRL) begin
				nxt_st.cpram_en = pwdata[CTRL_CPEN_BIT];
				nxt_st.prot     = pwdata[CTRL_ON_BIT];
			end else if (is_area_off(paddr) && (k < NUM_AREAS)) begin
				if (paddr[2]) begin
					nxt_st.areas[k].limit = pwdata[AW-1:0];
				end else begin
					nxt_st.areas[k].base = pwdata[AW-1:0];
				end
			end
		end

		// Leaving protection wins over any concurrent request
		if (leave_prot) begin
			nxt_st.prot = 1'b0;
		end

		// Forward only granted requests; a denied write dies here
		nxt_st.mem_req       = cpu_req;
		nxt_st.mem_req.valid = cpu_req.valid && allowed;
		nxt_st.denied        = cpu_req.valid && !allowed;
		// Held until the chip reset removes it
		nxt_st.rst_req       = st_ff.rst_req || (cpu_req.valid && !allowed);
	end

	// ==========================================
	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff          <= '0;
			for (int i = 0; i < NUM_AREAS; i++) begin
				st_ff.areas[i].base  <= AREA_BASE_RST;
				st_ff.areas[i].limit <= AREA_LIM_RST;
			end
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ==========================================
	// Outputs
	assign prdata        = st_ff.prdata;
	assign pready        = st_ff.pready;
	assign pslverr       = st_ff.pslverr;
	assign mem_req       = st_ff.mem_req;
	assign access_denied = st_ff.denied;
	assign chip_rst_req  = st_ff.rst_req;
	assign prot_status   = st_ff.prot;
	assign irq           = irq_q;

	// ==========================================
	// Assertions
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_denied_not_fwd: assert property (
		cpu_req.valid && !allowed |=> !mem_req.valid && access_denied)
		else $error("denied access was forwarded");

	a_denied_resets: assert property (
		cpu_req.valid && !allowed |=> chip_rst_req [*3])
		else $error("denied access without reset request");

	a_off_allows_all: assert property (
		!prot_status && cpu_req.valid |=> mem_req.valid && (mem_req.addr == $past(cpu_req.addr)))
		else $error("unprotected access was blocked");

	a_sysctl_blocked: assert property (
		prot_status && cpu_req.valid && (cpu_req.addr == SYSCTL_ADDR) && !leave_prot
		|=> !mem_req.valid)
		else $error("system control register reached while protected");

	a_ram_open: assert property (
		prot_status && cpu_req.valid && in_range(cpu_req.addr, RAM_LO, RAM_HI)
		&& (req_hit == '0) |=> mem_req.valid)
		else $error("plain RAM blocked while protected");

	a_irq_unprotects: assert property (
		prot_status && cpu_flow.irq_take |=> !prot_status ##1 (irq_stat[EV_IRQ_OFF]))
		else $error("interrupt did not clear protection");

	a_on_from_off: assert property (
		$rose(prot_status) |-> $past(psel && penable && pwrite && (paddr == OFF_CTRL)
		&& pwdata[CTRL_ON_BIT]))
		else $error("protection set without unprotected write");

	a_areas_locked: assert property (
		prot_status && !leave_prot |=> $stable(st_ff.areas) && $stable(st_ff.cpram_en))
		else $error("area rules changed while protected");

	a_call_relief: assert property (
		prot_status && cpu_flow.call && tgt_hit[A_CALL_RELIEF] |=> !prot_status)
		else $error("protected call into relief kept protection");

	a_apb_answer: assert property (
		psel && !penable |=> pready ##1 !pready)
		else $error("apb answer not one cycle");

	a_ret_relief: assert property (
		prot_status && cpu_flow.ret && tgt_hit[A_RET_RELIEF] |=> !prot_status)
		else $error("protected return into relief kept protection");

	a_exit_cause: assert property (
		$fell(prot_status) |-> $past(leave_prot))
		else $error("protection dropped without call, return or interrupt");

	a_cpram_open: assert property (
		prot_status && cpu_req.valid && req_hit[A_CPRAM] && st_ff.cpram_en |=> mem_req.valid)
		else $error("enabled shared window blocked");

	a_cpram_closed: assert property (
		prot_status && cpu_req.valid && req_hit[A_CPRAM] && !st_ff.cpram_en
		&& !req_hit[A_APP] && !req_hit[A_CALL_RELIEF] && !req_hit[A_RET_RELIEF]
		&& !in_range(cpu_req.addr, GPR_LO, GPR_HI) |=> access_denied)
		else $error("closed shared window reached while protected");

	a_exc_open: assert property (
		prot_status && cpu_req.valid
		&& (req_hit[A_APP] || req_hit[A_CALL_RELIEF] || req_hit[A_RET_RELIEF]) |=> mem_req.valid)
		else $error("exception window blocked while protected");

	a_outside_shut: assert property (
		prot_status && cpu_req.valid && (req_hit == '0)
		&& !in_range(cpu_req.addr, RAM_LO, RAM_HI) && !in_range(cpu_req.addr, GPR_LO, GPR_HI)
		|=> access_denied && !mem_req.valid)
		else $error("area outside RAM reached while protected");

	a_os_shut: assert property (
		prot_status && cpu_req.valid && (req_hit[A_OS_STACK] || req_hit[A_OS_WORK])
		&& !req_hit[A_CPRAM] && !req_hit[A_APP] && !req_hit[A_CALL_RELIEF]
		&& !req_hit[A_RET_RELIEF] && !in_range(cpu_req.addr, GPR_LO, GPR_HI) |=> access_denied)
		else $error("system window reached while protected");

	a_rst_sticky: assert property (
		chip_rst_req |=> chip_rst_req)
		else $error("reset request dropped before reset");

	a_deny_event: assert property (
		cpu_req.valid && !allowed |=> irq_stat[EV_DENY])
		else $error("denied access left no status bit");

	a_irq_level: assert property (
		irq == |(irq_stat & irq_mask))
		else $error("interrupt line disagrees with unmasked status");

	a_cfg_from_off: assert property (
		$changed(st_ff.areas) || $changed(st_ff.cpram_en) |-> !$past(prot_status))
		else $error("attributes changed by protected software");

	a_lock_err: assert property (
		psel && !penable && pwrite && prot_status && (paddr == OFF_CTRL) |=> pslverr)
		else $error("locked control write not refused");

	a_role_read: assert property (
		psel && !penable && !pwrite && (paddr == OFF_STATE)
		|=> prdata[ST_ROLE_BIT] == !$past(prot_status))
		else $error("role bit disagrees with protect status");

	a_off_no_deny: assert property (
		!prot_status && cpu_req.valid |=> !access_denied)
		else $error("access denied while unprotected");

	c_deny:    cover property (cpu_req.valid && !allowed);
	c_prot_on: cover property ($rose(prot_status));
	c_ret_off: cover property (ret_off);
	c_irq_out: cover property ($rose(irq));
	c_cpram:   cover property (prot_status && cpu_req.valid && cpram_ok);
endmodule // amg_guard

// file: sim/amg_cpu_mdl.sv
module amg_cpu_mdl
	import amg_pkg::*;
(
	input  wire logic            pclk,
	output amg_pkg::amg_cpu_req_t cpu_req,
	output amg_pkg::amg_flow_t    cpu_flow
);
	timeunit 1ns;
	timeprecision 1ps;
	import amg_pkg::*;

	initial begin
		cpu_req = '0;
		cpu_flow = '0;
	end

	// ==========================================
	// Data access, one cycle per request
	task automatic req(input logic w, input logic [23:0] a);
		@(posedge pclk);
		cpu_req <= '{1'b1, w, a};
		@(posedge pclk);
		// Idle address flips so a stale copy cannot pass
		cpu_req <= '{1'b0, 1'b0, ~a};
	endtask

	// ==========================================
	// Call, return or interrupt pulse
	task automatic fl(input logic c, input logic r, input logic i, input logic [23:0] t);
		@(posedge pclk);
		cpu_flow <= '{c, r, i, t};
		@(posedge pclk);
		cpu_flow <= '{1'b0, 1'b0, 1'b0, ~t};
	endtask
endmodule // amg_cpu_mdl

// file: sim/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import amg_pkg::*;

	logic         pclk = 1'b0;
	logic         presetn = 1'b0;
	logic         psel = 1'b0;
	logic         penable = 1'b0;
	logic         pwrite = 1'b0;
	logic [11:0]  paddr = '0;
	logic [31:0]  pwdata = '0;
	logic [31:0]  prdata;
	logic [31:0]  rd;
	logic         pready;
	logic         pslverr;
	logic         err;
	logic         access_denied;
	logic         chip_rst_req;
	logic         prot_status;
	logic         irq;
	amg_cpu_req_t cpu_req;
	amg_cpu_req_t mem_req;
	amg_flow_t    cpu_flow;
	int           n_fail = 0;
	int           checked = 0;

	always #20 pclk = ~pclk;

	amg_guard i_amg_guard (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_req(cpu_req), .cpu_flow(cpu_flow), .mem_req(mem_req),
		.access_denied(access_denied), .chip_rst_req(chip_rst_req),
		.prot_status(prot_status), .irq(irq)
	);
	amg_cpu_mdl i_amg_cpu_mdl (.pclk(pclk), .cpu_req(cpu_req), .cpu_flow(cpu_flow));

	// ==========================================
	// Shared tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask

	task automatic end_of_test;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			n_fail++;
			end_of_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic acc(input logic w, input logic [23:0] a, input logic ok);
		i_amg_cpu_mdl.req(w, a);
		#1;
		chk("mem_valid", ok, mem_req.valid);
		chk("mem_addr", a, mem_req.addr);
		chk("mem_wr", w, mem_req.write);
		chk("denied", !ok, access_denied);
	endtask

	task automatic flw(input logic [2:0] f, input logic [23:0] t, input logic p,
		input logic [3:0] st);
		i_amg_cpu_mdl.fl(f[2], f[1], f[0], t);
		#1;
		chk("prot", p, prot_status);
		apb(1'b0, OFF_IRQ_STAT, '0);
		chk("stat", st, rd);
		apb(1'b1, OFF_IRQ_STAT, 32'h0000000f);
		apb(1'b1, OFF_CTRL, 32'h00000001);
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset;
		chk("prot", 0, prot_status);
		apb(1'b0, OFF_STATE, '0);
		chk("state", 32'h2, rd);
		apb(1'b0, OFF_AREA0, '0);
		chk("base", 32'hffffff, rd);
		apb(1'b0, 12'h100, '0);
		chk("unmapped", 1, err);
		acc(1'b1, 24'h800000, 1'b1);
		acc(1'b1, SYSCTL_ADDR, 1'b1);
		$display("t_reset done");
	endtask

	task automatic t_config;
		logic [23:0] b [6] = '{24'h001000, 24'h002000, 24'h500000, 24'h200000,
			24'h300000, 24'h400000};
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, OFF_AREA0 + 12'(8 * i), {8'h00, b[i]});
			apb(1'b1, OFF_AREA0 + 12'(8 * i + 4), {8'h00, b[i] + 24'hff});
		end
		apb(1'b0, 12'h034, '0);
		chk("limit", 32'h3000ff, rd);
		apb(1'b1, OFF_IRQ_MASK, 32'h0000000f);
		apb(1'b1, OFF_CTRL, 32'h00000001);
		#1;
		chk("prot_on", 1, prot_status);
		apb(1'b0, OFF_STATE, '0);
		chk("state", 32'h1, rd);
		$display("t_config done");
	endtask

	task automatic t_prot;
		acc(1'b1, 24'h000100, 1'b1);
		acc(1'b0, 24'h000100, 1'b1);
		acc(1'b0, 24'h001010, 1'b0);
		acc(1'b1, 24'h002010, 1'b0);
		acc(1'b0, 24'h500010, 1'b0);
		acc(1'b0, 24'h800000, 1'b0);
		acc(1'b1, 24'h200010, 1'b1);
		acc(1'b0, 24'h300010, 1'b1);
		acc(1'b0, 24'h400010, 1'b1);
		acc(1'b1, 24'h010004, 1'b1);
		acc(1'b1, SYSCTL_ADDR, 1'b0);
		chk("rst_req", 1, chip_rst_req);
		chk("irq", 1, irq);
		apb(1'b1, OFF_AREA0, 32'h0);
		chk("locked", 1, err);
		apb(1'b1, OFF_CTRL, 32'h0);
		chk("ctrl_lock", 1, err);
		apb(1'b0, OFF_AREA0, '0);
		chk("base_kept", 32'h001000, rd);
		apb(1'b1, OFF_IRQ_STAT, 32'h0000000f);
		#1;
		chk("irq_clr", 0, irq);
		$display("t_prot done");
	endtask

	task automatic t_exit;
		flw(3'b100, 24'h300010, 1'b0, 4'h2);
		flw(3'b010, 24'h400010, 1'b0, 4'h4);
		// Call aimed at the wrong relief window must not unlock
		flw(3'b100, 24'h400010, 1'b1, 4'h0);
		flw(3'b001, 24'h000000, 1'b0, 4'h8);
		apb(1'b1, OFF_IRQ_MASK, 32'h0);
		i_amg_cpu_mdl.fl(1'b0, 1'b0, 1'b1, 24'h0);
		#41;
		chk("irq_masked", 0, irq);
		$display("t_exit done");
	endtask

	task automatic t_cpram;
		apb(1'b1, OFF_CTRL, 32'h00000003);
		acc(1'b0, 24'h500010, 1'b1);
		$display("t_cpram done");
	endtask

	task automatic t_rst_mid;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk("rst_clr", 0, chip_rst_req);
		chk("prot_rst", 0, prot_status);
		apb(1'b0, OFF_AREA0 + 12'h004, '0);
		chk("limit_rst", 32'h0, rd);
		acc(1'b0, 24'h001010, 1'b1);
		$display("t_rst_mid done");
	endtask

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_config();
		t_prot();
		t_exit();
		t_cpram();
		t_rst_mid();
		end_of_test();
	end
endmodule // tb_top
